/* hw/async_serial_transceiver.sv */
// Asynchronous serial transceiver with APB register access and shared pin steering.
module async_serial_transceiver (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [async_serial_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [async_serial_pkg::DATA_W-1:0] pwdata_in,
  output logic [async_serial_pkg::DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic timer_rate_in,
  input wire logic rx_pin_in,
  input wire async_serial_pkg::pin_drive_t spi_drive_in,
  input wire async_serial_pkg::pin_drive_t port_drive_in,
  output async_serial_pkg::pin_drive_t tx_pin_out,
  output logic spi_rx_data_out,
  output logic port_rx_data_out,
  output logic transmit_empty_irq_out,
  output logic receive_full_irq_out,
  output logic receive_error_irq_out
);
  import async_serial_pkg::*;

  control_one_t ctl_reg;
  logic [7:0] hold_reg;
  logic hold_ninth_reg;
  logic hold_full_reg;
  logic even_reg;
  logic par_en_reg;
  logic rx_en_reg;
  logic perr_reg;
  logic oerr_reg;
  logic ferr_reg;
  logic full_reg;
  logic [7:0] rx_buf_reg;
  logic rx_ninth_reg;
  logic [2:0] irq_en_reg;
  pin_mode_t pin_mode_reg;
  logic [DATA_W-1:0] prdata_reg;
  logic [8:0] div_cnt_reg;
  logic rx_meta_reg;
  logic rx_sync_reg;
  logic rx_prev_reg;
  frame_state_t tx_state_reg;
  logic [3:0] tx_tick_reg;
  logic [3:0] tx_bit_reg;
  logic [8:0] tx_shift_reg;
  logic tx_par_reg;
  logic tx_line_reg;
  frame_state_t rx_state_reg;
  logic [3:0] rx_tick_reg;
  logic [3:0] rx_bit_reg;
  logic [8:0] rx_shift_reg;
  logic [2:0] rx_samp_reg;
  logic rx_par_reg;
  logic tx_empty_pulse_reg;
  logic rx_full_pulse_reg;
  logic rx_err_pulse_reg;

  logic access;
  logic wr_fire;
  logic rd_fire;
  logic mapped;
  logic baud_tick;
  logic [3:0] n_bits;
  logic par_on;
  logic rx_listen;
  logic rx_bit;
  logic rx_done;
  logic [7:0] rx_data_next;
  logic rx_ninth_next;
  logic rx_perr_next;
  logic rx_ferr_next;
  logic tx_load;
  logic tx_done;
  logic [8:0] div_max;
  status_t status_view;
  control_one_t control_view;

  function automatic logic majority(input logic [2:0] s);
    majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // Frame shape: length field and parity, with no parity at nine bits.
  always_comb begin
    case (ctl_reg.data_length_field)
      LEN_SEVEN: n_bits = BITS_SEVEN;
      LEN_EIGHT: n_bits = BITS_EIGHT;
      LEN_NINE: n_bits = BITS_NINE;
      default: n_bits = BITS_EIGHT;
    endcase
  end
  assign par_on = par_en_reg && (ctl_reg.data_length_field != LEN_NINE);

  // APB slave: zero wait states, read data captured in the setup cycle.
  assign access = psel_in & penable_in;
  assign wr_fire = access & pwrite_in;
  assign rd_fire = access & ~pwrite_in;
  assign pready_out = access;
  assign pslverr_out = access & ~mapped;
  assign prdata_out = prdata_reg;

  always_comb begin
    case (paddr_in)
      CONTROL_ONE_OFFSET,
      STATUS_OFFSET,
      RECEIVE_BUFFER_OFFSET,
      TRANSMIT_BUFFER_OFFSET,
      IRQ_ENABLE_OFFSET,
      PIN_MODE_OFFSET: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    control_view = ctl_reg;
    control_view.transmit_buffer_empty_bit = ~hold_full_reg;
    status_view = '{receive_ninth_bit: rx_ninth_reg, even_parity: even_reg,
                    parity_enable: par_en_reg, parity_error_flag: perr_reg,
                    overrun_error_flag: oerr_reg, framing_error_flag: ferr_reg,
                    receive_buffer_full_bit: full_reg, receive_enable_bit: rx_en_reg};
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      prdata_reg <= '0;
    end else if (psel_in && !penable_in) begin
      case (paddr_in)
        CONTROL_ONE_OFFSET: prdata_reg <= {24'h000000, control_view};
        STATUS_OFFSET: prdata_reg <= {24'h000000, status_view};
        RECEIVE_BUFFER_OFFSET: prdata_reg <= {24'h000000, rx_buf_reg};
        IRQ_ENABLE_OFFSET: prdata_reg <= {29'h00000000, irq_en_reg};
        PIN_MODE_OFFSET: prdata_reg <= {30'h00000000, pin_mode_reg};
        default: prdata_reg <= '0;
      endcase
    end
  end

  // Control, enable and pin mode storage.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      ctl_reg <= '0;
      even_reg <= 1'b0;
      par_en_reg <= 1'b0;
      rx_en_reg <= 1'b0;
      irq_en_reg <= '0;
      pin_mode_reg <= PIN_PORT;
    end else if (wr_fire) begin
      case (paddr_in)
        CONTROL_ONE_OFFSET: ctl_reg <= control_one_t'(pwdata_in[7:0]);
        STATUS_OFFSET: begin
          even_reg <= pwdata_in[6];
          par_en_reg <= pwdata_in[5];
          rx_en_reg <= pwdata_in[0];
        end
        IRQ_ENABLE_OFFSET: irq_en_reg <= pwdata_in[2:0];
        PIN_MODE_OFFSET: pin_mode_reg <= pin_mode_t'(pwdata_in[1:0]);
        default: ;
      endcase
    end
  end

  // Baud divider: one tick per sixteenth of a bit, shared by both directions.
  assign div_max = (ctl_reg.baud_select_field <= BAUD_LAST_DIV) ?
                   BAUD_DIV_TABLE[ctl_reg.baud_select_field] - 9'h001 : '0;

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in || div_cnt_reg >= div_max) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 9'h001;
    end
  end

  always_comb begin
    if (ctl_reg.baud_select_field <= BAUD_LAST_DIV) begin
      baud_tick = (div_cnt_reg >= div_max);
    end else if (ctl_reg.baud_select_field == BAUD_TIMER) begin
      baud_tick = timer_rate_in;
    end else begin
      baud_tick = 1'b0;
    end
  end

  // Transmit holding stage; a load into the shifter empties it.
  assign tx_load = (tx_state_reg == ST_IDLE) && hold_full_reg && ctl_reg.transmit_enable_bit;

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      hold_reg <= '0;
      hold_ninth_reg <= 1'b0;
      hold_full_reg <= 1'b0;
    end else if (wr_fire && paddr_in == TRANSMIT_BUFFER_OFFSET) begin
      hold_reg <= pwdata_in[7:0];
      hold_ninth_reg <= ctl_reg.transmit_ninth_bit;
      hold_full_reg <= 1'b1;
    end else if (tx_load) begin
      hold_full_reg <= 1'b0;
    end
  end

  // Transmit shifter: start, data LSB first, parity, stop, then mark.
  assign tx_done = (tx_state_reg == ST_STOP) && baud_tick && (tx_tick_reg == TICK_LAST);

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      tx_state_reg <= ST_IDLE;
      tx_tick_reg <= '0;
      tx_bit_reg <= '0;
      tx_shift_reg <= '0;
      tx_par_reg <= 1'b0;
      tx_line_reg <= 1'b1;
    end else if (tx_load) begin
      tx_state_reg <= ST_START;
      tx_tick_reg <= '0;
      tx_bit_reg <= '0;
      tx_shift_reg <= {hold_ninth_reg, hold_reg};
      tx_par_reg <= ~even_reg;
      tx_line_reg <= 1'b0;
    end else if (baud_tick) begin
      tx_tick_reg <= tx_tick_reg + 4'h1;
      if (tx_tick_reg == TICK_LAST) begin
        case (tx_state_reg)
          ST_START, ST_DATA: begin
            if (tx_state_reg == ST_DATA && tx_bit_reg == n_bits) begin
              tx_state_reg <= par_on ? ST_PARITY : ST_STOP;
              tx_line_reg <= par_on ? tx_par_reg : 1'b1;
            end else begin
              tx_state_reg <= ST_DATA;
              tx_line_reg <= tx_shift_reg[0];
              tx_par_reg <= tx_par_reg ^ tx_shift_reg[0];
              tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
              tx_bit_reg <= tx_bit_reg + 4'h1;
            end
          end
          ST_PARITY: begin
            tx_state_reg <= ST_STOP;
            tx_line_reg <= 1'b1;
          end
          ST_STOP: begin
            tx_state_reg <= ST_IDLE;
            tx_line_reg <= 1'b1;
          end
          default: begin
            tx_state_reg <= ST_IDLE;
            tx_line_reg <= 1'b1;
          end
        endcase
      end
    end
  end

  // Receive pin synchroniser; the edge detector compares the second and third stages.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_meta_reg <= rx_pin_in;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  assign rx_listen = rx_en_reg && (pin_mode_reg == PIN_SERIAL);
  assign rx_bit = majority(rx_samp_reg);

  // Receive framer: three mid-bit samples per bit, majority vote.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in || !rx_listen) begin
      rx_state_reg <= ST_IDLE;
      rx_tick_reg <= '0;
      rx_bit_reg <= '0;
      rx_shift_reg <= '0;
      rx_samp_reg <= '1;
      rx_par_reg <= 1'b0;
    end else if (rx_state_reg == ST_IDLE) begin
      if (rx_prev_reg && !rx_sync_reg) begin
        rx_state_reg <= ST_START;
        rx_tick_reg <= '0;
        rx_bit_reg <= '0;
        rx_par_reg <= ~even_reg;
      end
    end else if (baud_tick) begin
      rx_tick_reg <= rx_tick_reg + 4'h1;
      if (rx_tick_reg == SAMPLE_FIRST) begin
        rx_samp_reg[0] <= rx_sync_reg;
      end
      if (rx_tick_reg == SAMPLE_MID) begin
        rx_samp_reg[1] <= rx_sync_reg;
      end
      if (rx_tick_reg == SAMPLE_LAST) begin
        rx_samp_reg[2] <= rx_sync_reg;
      end
      if (rx_tick_reg == TICK_LAST) begin
        case (rx_state_reg)
          ST_START: rx_state_reg <= rx_bit ? ST_IDLE : ST_DATA;
          ST_DATA: begin
            rx_shift_reg <= {rx_bit, rx_shift_reg[8:1]};
            rx_par_reg <= rx_par_reg ^ rx_bit;
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg + 4'h1 == n_bits) begin
              rx_state_reg <= par_on ? ST_PARITY : ST_STOP;
            end
          end
          ST_PARITY: begin
            rx_par_reg <= rx_par_reg ^ rx_bit;
            rx_state_reg <= ST_STOP;
          end
          default: rx_state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  assign rx_done = rx_listen && (rx_state_reg == ST_STOP) && baud_tick &&
                   (rx_tick_reg == TICK_LAST);
  assign rx_perr_next = par_on && rx_par_reg;
  assign rx_ferr_next = ~rx_bit;

  always_comb begin
    rx_ninth_next = 1'b0;
    case (ctl_reg.data_length_field)
      LEN_SEVEN: rx_data_next = {1'b0, rx_shift_reg[8:2]};
      LEN_NINE: begin
        rx_data_next = rx_shift_reg[7:0];
        rx_ninth_next = rx_shift_reg[8];
      end
      default: rx_data_next = rx_shift_reg[8:1];
    endcase
  end

  // Receive holding stage and its flags; hardware sets win over clears.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      rx_buf_reg <= '0;
      rx_ninth_reg <= 1'b0;
    end else if (rx_done) begin
      rx_buf_reg <= rx_data_next;
      rx_ninth_reg <= rx_ninth_next;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      full_reg <= 1'b0;
    end else if (rx_done) begin
      full_reg <= 1'b1;
    end else if (rd_fire && paddr_in == RECEIVE_BUFFER_OFFSET) begin
      full_reg <= 1'b0;
    end else if (wr_fire && paddr_in == STATUS_OFFSET && pwdata_in[0] && !rx_en_reg) begin
      full_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      perr_reg <= 1'b0;
      oerr_reg <= 1'b0;
      ferr_reg <= 1'b0;
    end else begin
      // Writing one clears a flag, but a new error in that cycle keeps it set.
      if (wr_fire && paddr_in == STATUS_OFFSET) begin
        perr_reg <= perr_reg & ~pwdata_in[4];
        oerr_reg <= oerr_reg & ~pwdata_in[3];
        ferr_reg <= ferr_reg & ~pwdata_in[2];
      end
      if (rx_done && rx_perr_next) begin
        perr_reg <= 1'b1;
      end
      if (rx_done && full_reg) begin
        oerr_reg <= 1'b1;
      end
      if (rx_done && rx_ferr_next) begin
        ferr_reg <= 1'b1;
      end
    end
  end

  // Request pulses; a flag left set re-raises the error request on each byte.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      tx_empty_pulse_reg <= 1'b0;
      rx_full_pulse_reg <= 1'b0;
      rx_err_pulse_reg <= 1'b0;
    end else begin
      tx_empty_pulse_reg <= tx_done && irq_en_reg[IEN_TX_EMPTY];
      rx_full_pulse_reg <= rx_done && irq_en_reg[IEN_RX_FULL];
      rx_err_pulse_reg <= rx_done && irq_en_reg[IEN_RX_ERROR] &&
                          (rx_perr_next || rx_ferr_next || full_reg ||
                           perr_reg || oerr_reg || ferr_reg);
    end
  end

  assign transmit_empty_irq_out = tx_empty_pulse_reg;
  assign receive_full_irq_out = rx_full_pulse_reg;
  assign receive_error_irq_out = rx_err_pulse_reg;

  // Shared pin steering, registered so the pin never glitches between owners.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      tx_pin_out <= '{value: 1'b1, enable: 1'b0};
      spi_rx_data_out <= 1'b1;
      port_rx_data_out <= 1'b1;
    end else begin
      if (pin_mode_reg == PIN_SPI) begin
        tx_pin_out <= spi_drive_in;
      end else if (pin_mode_reg == PIN_SERIAL && ctl_reg.transmit_enable_bit) begin
        tx_pin_out <= '{value: tx_line_reg, enable: 1'b1};
      end else begin
        tx_pin_out <= port_drive_in;
      end
      spi_rx_data_out <= (pin_mode_reg == PIN_SPI) ? rx_sync_reg : 1'b1;
      port_rx_data_out <= (pin_mode_reg == PIN_PORT) ? rx_sync_reg : 1'b1;
    end
  end
endmodule

/* hw/async_serial_pkg.sv */
// Constants, types and register map of the asynchronous serial transceiver.
package async_serial_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] CONTROL_ONE_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] RECEIVE_BUFFER_OFFSET = 8'h08;
  localparam logic [ADDR_W-1:0] TRANSMIT_BUFFER_OFFSET = 8'h0c;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFFSET = 8'h10;
  localparam logic [ADDR_W-1:0] PIN_MODE_OFFSET = 8'h14;
  localparam int IEN_TX_EMPTY = 0;
  localparam int IEN_RX_FULL = 1;
  localparam int IEN_RX_ERROR = 2;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] SAMPLE_FIRST = 4'h7;
  localparam logic [3:0] SAMPLE_MID = 4'h8;
  localparam logic [3:0] SAMPLE_LAST = 4'h9;
  localparam logic [3:0] BITS_SEVEN = 4'h7;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  localparam logic [2:0] BAUD_TIMER = 3'h6;
  localparam logic [2:0] BAUD_LAST_DIV = 3'h5;
  localparam logic [5:0][8:0] BAUD_DIV_TABLE = {9'h1a0, 9'h0d0, 9'h068, 9'h034, 9'h01a, 9'h00d};
  typedef enum logic [1:0] {LEN_SEVEN = 2'b00, LEN_EIGHT = 2'b01, LEN_NINE = 2'b10,
                            LEN_RSVD = 2'b11} data_length_t;
  typedef enum logic [1:0] {PIN_PORT = 2'b00, PIN_SPI = 2'b01, PIN_SERIAL = 2'b10,
                            PIN_RSVD = 2'b11} pin_mode_t;
  typedef enum logic [2:0] {ST_IDLE = 3'b000, ST_START = 3'b001, ST_DATA = 3'b010,
                            ST_PARITY = 3'b011, ST_STOP = 3'b100} frame_state_t;
  typedef struct packed {
    logic transmit_ninth_bit;
    data_length_t data_length_field;
    logic [2:0] baud_select_field;
    logic transmit_buffer_empty_bit;
    logic transmit_enable_bit;
  } control_one_t;
  typedef struct packed {
    logic receive_ninth_bit;
    logic even_parity;
    logic parity_enable;
    logic parity_error_flag;
    logic overrun_error_flag;
    logic framing_error_flag;
    logic receive_buffer_full_bit;
    logic receive_enable_bit;
  } status_t;
  typedef struct packed {
    logic value;
    logic enable;
  } pin_drive_t;
endpackage

/* test/async_serial_chk.sv */
// Port-level assertions for the asynchronous serial transceiver.
module async_serial_chk (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [async_serial_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [async_serial_pkg::DATA_W-1:0] pwdata_in,
  input wire logic [async_serial_pkg::DATA_W-1:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic timer_rate_in,
  input wire logic rx_pin_in,
  input wire async_serial_pkg::pin_drive_t spi_drive_in,
  input wire async_serial_pkg::pin_drive_t port_drive_in,
  input wire async_serial_pkg::pin_drive_t tx_pin_out,
  input wire logic spi_rx_data_out,
  input wire logic port_rx_data_out,
  input wire logic transmit_empty_irq_out,
  input wire logic receive_full_irq_out,
  input wire logic receive_error_irq_out
);
  import async_serial_pkg::*;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // The stop bit lasts at least 208 cycles, so three looks back all land inside it.
  sequence s_stop_high;
    $past(tx_pin_out.value, 1) && $past(tx_pin_out.value, 100) && $past(tx_pin_out.value, 200);
  endsequence
  sequence s_start_low;
    !tx_pin_out.value [*8];
  endsequence
  property p_tx_empty_irq;
    transmit_empty_irq_out |-> s_stop_high ##1 !transmit_empty_irq_out;
  endproperty
  property p_start_bit;
    $fell(tx_pin_out.value) |-> s_start_low;
  endproperty
  property p_tx_buf_read;
    psel_in && penable_in && !pwrite_in && paddr_in == TRANSMIT_BUFFER_OFFSET |-> prdata_out == '0;
  endproperty
  property p_upper_zero;
    psel_in && penable_in |-> prdata_out[31:8] == '0;
  endproperty
  property p_full_pulse;
    $rose(receive_full_irq_out) |=> !receive_full_irq_out;
  endproperty
  property p_err_pulse;
    receive_error_irq_out |=> !receive_error_irq_out;
  endproperty
  property p_pin_sense;
    spi_rx_data_out || port_rx_data_out;
  endproperty
  property p_rxbuf_ok;
    psel_in && penable_in && paddr_in == RECEIVE_BUFFER_OFFSET |-> pready_out && !pslverr_out;
  endproperty
  a_tx_empty_irq: assert property (p_tx_empty_irq)
    else $error("empty request not after stop bit");
  a_start_bit: assert property (p_start_bit)
    else $error("start bit too short");
  a_tx_buf_read: assert property (p_tx_buf_read)
    else $error("transmit buffer readable");
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read bits set");
  a_full_pulse: assert property (p_full_pulse)
    else $error("full request too long");
  a_err_pulse: assert property (p_err_pulse)
    else $error("error request too long");
  a_pin_sense: assert property (p_pin_sense)
    else $error("receive pin given to two users");
  a_rxbuf_ok: assert property (p_rxbuf_ok)
    else $error("receive buffer access refused");
endmodule
bind async_serial_transceiver async_serial_chk chk_i (.core_clk_in, .rst_b_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
  .timer_rate_in, .rx_pin_in, .spi_drive_in, .port_drive_in, .tx_pin_out, .spi_rx_data_out,
  .port_rx_data_out, .transmit_empty_irq_out, .receive_full_irq_out, .receive_error_irq_out);

/* test/serial_peer.sv */
// Remote serial device model facing the transceiver's transmit and receive pins.
module serial_peer (
  input wire logic clk_in,
  input wire async_serial_pkg::pin_drive_t tx_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import async_serial_pkg::*;
  int bit_len = 208;
  logic tx_wire;
  // An undriven transmit pin is read through a pull-up, so it looks idle.
  assign tx_wire = tx_in.enable ? tx_in.value : 1'h1;
  initial line_out = 1'h1;
  task automatic hold(input logic v, input int n);
    line_out <= v;
    repeat (n) @(posedge clk_in);
  endtask
  task automatic send(input logic [9:0] f, input int n, input logic s);
    @(posedge clk_in);
    hold(1'h0, bit_len);
    for (int i = 0; i < n; i++) hold(f[i], bit_len);
    hold(s, bit_len);
    line_out <= 1'h1;
  endtask
  task automatic glitch(input int n);
    @(posedge clk_in);
    hold(1'h0, n);
    line_out <= 1'h1;
  endtask
  // Samples mid-bit; the last bit taken is the stop bit only when n counts every data and parity bit plus the stop bit.
  // Looks on the falling clock edge, away from the edge that moves the pin.
  // It waits for a high line first, since a plain port drive may hold the pin low.
  task automatic grab(input int n, output logic [9:0] v);
    v = '0;
    while (tx_wire !== 1'h1) @(negedge clk_in);
    while (tx_wire !== 1'h0) @(negedge clk_in);
    repeat (bit_len / 2) @(negedge clk_in);
    for (int i = 0; i < n; i++) begin
      repeat (bit_len) @(negedge clk_in);
      v[i] = tx_wire;
    end
  endtask
endmodule

/* test/tb.sv */
// Self-checking bench for the asynchronous serial transceiver.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import async_serial_pkg::*;
  logic core_clk_in = 1'h0;
  logic rst_b_in = 1'h0;
  logic psel_in = 1'h0;
  logic penable_in = 1'h0;
  logic pwrite_in = 1'h0;
  logic [ADDR_W-1:0] paddr_in = '0;
  logic [DATA_W-1:0] pwdata_in = '0;
  logic [DATA_W-1:0] prdata_out;
  logic pready_out, pslverr_out, rx_pin_in, spi_rx_data_out, port_rx_data_out, sl;
  logic transmit_empty_irq_out, receive_full_irq_out, receive_error_irq_out;
  pin_drive_t tx_pin_out;
  pin_drive_t spi_drive_in = 2'h0;
  pin_drive_t port_drive_in = 2'h1;
  logic timer_rate_in = 1'h0;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0, tx_irqs = 0, full_irqs = 0, err_irqs = 0;
  logic [31:0] r;
  logic [9:0] g;
  async_serial_transceiver DUT (.core_clk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .timer_rate_in, .rx_pin_in,
    .spi_drive_in, .port_drive_in, .tx_pin_out, .spi_rx_data_out, .port_rx_data_out,
    .transmit_empty_irq_out, .receive_full_irq_out, .receive_error_irq_out);
  serial_peer peer (.clk_in(core_clk_in), .tx_in(tx_pin_out), .line_out(rx_pin_in));
  initial forever #4 core_clk_in = ~core_clk_in;
  task automatic wrap_up();
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Timer three stand-in: one tick every 13 clocks, the same rate as code zero.
  always @(posedge core_clk_in) begin
    timer_rate_in <= (cycles % 13 == 0);
  end
  // Request pulses are counted on the falling edge, where they have settled.
  always @(negedge core_clk_in) begin
    cycles <= cycles + 1;
    if (transmit_empty_irq_out === 1'h1) tx_irqs <= tx_irqs + 1;
    if (receive_full_irq_out === 1'h1) full_irqs <= full_irqs + 1;
    if (receive_error_irq_out === 1'h1) err_irqs <= err_irqs + 1;
    if (cycles == 80000) begin
      bad_count = bad_count + 1;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    psel_in <= 1'h1;
    penable_in <= 1'h0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'h1;
    @(posedge core_clk_in);
    while (pready_out !== 1'h1) @(posedge core_clk_in);
    r = prdata_out;
    sl = pslverr_out;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(r, e);
  endtask
  task automatic txc(input logic [7:0] st, ct, d, input int n, input logic [9:0] e);
    repeat (150) @(posedge core_clk_in);
    wr(STATUS_OFFSET, st);
    wr(CONTROL_ONE_OFFSET, ct);
    fork
      peer.grab(n, g);
      wr(TRANSMIT_BUFFER_OFFSET, d);
    join
    chk(g, e);
  endtask
  task automatic rxs(input logic [9:0] f, input int n, input logic s, input logic [7:0] es, eb);
    peer.send(f, n, s);
    repeat (40) @(posedge core_clk_in);
    rd(STATUS_OFFSET, es);
    rd(RECEIVE_BUFFER_OFFSET, eb);
  endtask
  initial begin
    repeat (20) @(posedge core_clk_in);
    rst_b_in <= 1'h1;
    rd(CONTROL_ONE_OFFSET, 32'h2);
    rd(STATUS_OFFSET, 32'h0);
    rd(8'h18, 32'h0);
    chk(sl, 1'h1);
    wr(IRQ_ENABLE_OFFSET, 32'h7);
    wr(CONTROL_ONE_OFFSET, 32'h21);
    // Expected pin drive and receive routing for pin modes 0 to 3.
    for (int m = 0; m < 4; m++) begin
      wr(PIN_MODE_OFFSET, m);
      fork
        peer.send(10'h0, 8, 1'h1);
        begin
          repeat (30) @(posedge core_clk_in);
          chk(tx_pin_out, 8'h71 >> (2 * m) & 2'h3);
          chk({spi_rx_data_out, port_rx_data_out}, 8'hf6 >> (2 * m) & 2'h3);
        end
      join
    end
    wr(PIN_MODE_OFFSET, 32'h2);
    wr(CONTROL_ONE_OFFSET, 32'h20);
    wr(TRANSMIT_BUFFER_OFFSET, 32'h81);
    repeat (300) @(posedge core_clk_in);
    chk(tx_pin_out, 2'h1);
    rd(CONTROL_ONE_OFFSET, 32'h20);
    rd(TRANSMIT_BUFFER_OFFSET, 32'h0);
    fork
      peer.grab(9, g);
      wr(CONTROL_ONE_OFFSET, 32'h21);
    join
    chk(g, 10'h181);
    // Let the shifter finish, so the holding stage takes exactly one waiting character.
    repeat (150) @(posedge core_clk_in);
    fork
      begin
        peer.grab(9, g);
        chk(g, 10'h1a3);
        peer.grab(9, g);
        chk(g, 10'h13c);
      end
      begin
        wr(TRANSMIT_BUFFER_OFFSET, 32'ha3);
        wr(TRANSMIT_BUFFER_OFFSET, 32'h3c);
      end
    join
    repeat (150) @(posedge core_clk_in);
    chk(tx_irqs, 3);
    rd(CONTROL_ONE_OFFSET, 32'h23);
    txc(8'h60, 8'h01, 8'h5b, 9, 10'h1db);
    txc(8'h20, 8'h01, 8'h5b, 9, 10'h15b);
    txc(8'h20, 8'hc1, 8'h3c, 10, 10'h33c);
    repeat (150) @(posedge core_clk_in);
    wr(CONTROL_ONE_OFFSET, 32'h21);
    wr(STATUS_OFFSET, 32'h1);
    rxs(10'h96, 8, 1'h1, 8'h03, 8'h96);
    rd(STATUS_OFFSET, 32'h1);
    wr(RECEIVE_BUFFER_OFFSET, 32'h5a);
    rd(RECEIVE_BUFFER_OFFSET, 32'h96);
    peer.send(10'h11, 8, 1'h1);
    rxs(10'h22, 8, 1'h1, 8'h0b, 8'h22);
    chk(err_irqs, 1);
    wr(STATUS_OFFSET, 32'h09);
    rxs(10'h5a, 8, 1'h0, 8'h07, 8'h5a);
    wr(STATUS_OFFSET, 32'h65);
    rxs(10'h103, 9, 1'h1, 8'h73, 8'h03);
    rxs(10'h107, 9, 1'h1, 8'h73, 8'h07);
    wr(STATUS_OFFSET, 32'h31);
    rxs(10'h103, 9, 1'h1, 8'h23, 8'h03);
    wr(CONTROL_ONE_OFFSET, 32'h41);
    rxs(10'h1a5, 9, 1'h1, 8'ha3, 8'ha5);
    peer.glitch(40);
    repeat (400) @(posedge core_clk_in);
    rd(STATUS_OFFSET, 32'ha1);
    wr(STATUS_OFFSET, 32'h20);
    peer.send(10'h0f, 9, 1'h1);
    repeat (40) @(posedge core_clk_in);
    rd(STATUS_OFFSET, 32'ha0);
    chk(full_irqs, 8);
    chk(err_irqs, 4);
    peer.bit_len = 416;
    txc(8'h01, 8'h25, 8'h69, 9, 10'h169);
    peer.send(10'h3c, 8, 1'h1);
    repeat (40) @(posedge core_clk_in);
    rd(RECEIVE_BUFFER_OFFSET, 32'h3c);
    peer.bit_len = 208;
    txc(8'h01, 8'h39, 8'hc3, 9, 10'h1c3);
    wrap_up();
  end
endmodule
